// ==== rtl/resonant_sr_dead_time.sv ====
// Resonant-mode rectifier dead-time timing with AXI4-Lite registers.
`timescale 1ns/1ps
module resonant_sr_dead_time #(
  parameter int CW = 16
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // AXI4-Lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // AC sense and rectifier drives
  input  wire logic        ac_edge_sense_input,
  output logic             rectifier_drive_one,
  output logic             rectifier_drive_two
);
  localparam int OW = $clog2(sr_timing_pkg::MAX_OFFSET_CYCLES + 1);

  // ************************************************************************
  // Helpers
  // ************************************************************************
  // code to cycles
  function automatic logic [OW-1:0] code_to_cycles(input logic [7:0] code);
    int ns;
    ns = int'(code) * sr_timing_pkg::LSB_NS;
    return OW'((ns + sr_timing_pkg::CLK_NS - 1) / sr_timing_pkg::CLK_NS);
  endfunction : code_to_cycles

  // The drive flop lags the AC edge it is timed from by two clocks. The
  // early fall is pulled in by the same amount, otherwise every lead would
  // come out two clocks short and a small lead would overlap the AC edge.
  // lead with latency
  function automatic logic [OW-1:0] lead_to_cycles(input logic [7:0] code);
    return code_to_cycles(code) + OW'(sr_timing_pkg::EDGE_LATENCY);
  endfunction : lead_to_cycles

  function automatic logic mapped(input logic [7:0] idx);
    return idx == sr_timing_pkg::IDX_RECT1_RISE_DELAY ||
           idx == sr_timing_pkg::IDX_RECT1_FALL_LEAD  ||
           idx == sr_timing_pkg::IDX_RECT2_RISE_DELAY ||
           idx == sr_timing_pkg::IDX_RECT2_FALL_LEAD  ||
           idx == sr_timing_pkg::IDX_CONTROL          ||
           idx == sr_timing_pkg::IDX_STATUS;
  endfunction : mapped

  // ************************************************************************
  // Write channel
  // ************************************************************************
  logic [7:0] aw_idx_q;
  logic       aw_held_q;
  logic [7:0] w_data_q;
  logic       w_en_q;
  logic       w_held_q;
  logic [7:0] rect1_rise_delay_q;
  logic [7:0] rect1_fall_lead_q;
  logic [7:0] rect2_rise_delay_q;
  logic [7:0] rect2_fall_lead_q;
  logic [7:0] control_q;
  logic       do_write;

  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held_q     <= 1'b0;
      aw_idx_q      <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !s_axi_awready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_idx_q  <= s_axi_awaddr[9:2];
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      w_held_q     <= 1'b0;
      w_data_q     <= '0;
      w_en_q       <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_q && !s_axi_wready;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_en_q   <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= sr_timing_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(aw_idx_q) ? sr_timing_pkg::RESP_OKAY
                                       : sr_timing_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rect1_rise_delay_q <= sr_timing_pkg::DEAD_TIME_RESET;
      rect1_fall_lead_q  <= sr_timing_pkg::DEAD_TIME_RESET;
      rect2_rise_delay_q <= sr_timing_pkg::DEAD_TIME_RESET;
      rect2_fall_lead_q  <= sr_timing_pkg::DEAD_TIME_RESET;
      control_q          <= sr_timing_pkg::CONTROL_RESET;
    end else if (do_write && w_en_q) begin
      case (aw_idx_q)
        sr_timing_pkg::IDX_RECT1_RISE_DELAY: rect1_rise_delay_q <= w_data_q;
        sr_timing_pkg::IDX_RECT1_FALL_LEAD:  rect1_fall_lead_q  <= w_data_q;
        sr_timing_pkg::IDX_RECT2_RISE_DELAY: rect2_rise_delay_q <= w_data_q;
        sr_timing_pkg::IDX_RECT2_FALL_LEAD:  rect2_fall_lead_q  <= w_data_q;
        sr_timing_pkg::IDX_CONTROL:          control_q          <= w_data_q;
        default: ;
      endcase
    end
  end

  // ************************************************************************
  // Read channel
  // ************************************************************************
  logic [7:0] rd_byte;
  logic [7:0] ar_idx;
  logic       ar_take;
  logic       ac_prev_q;

  assign ar_idx  = s_axi_araddr[9:2];
  assign ar_take = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rd_byte = 8'h00;
    case (ar_idx)
      sr_timing_pkg::IDX_RECT1_RISE_DELAY: rd_byte = rect1_rise_delay_q;
      sr_timing_pkg::IDX_RECT1_FALL_LEAD:  rd_byte = rect1_fall_lead_q;
      sr_timing_pkg::IDX_RECT2_RISE_DELAY: rd_byte = rect2_rise_delay_q;
      sr_timing_pkg::IDX_RECT2_FALL_LEAD:  rd_byte = rect2_fall_lead_q;
      sr_timing_pkg::IDX_CONTROL:          rd_byte = control_q;
      sr_timing_pkg::IDX_STATUS: begin
        rd_byte[sr_timing_pkg::STAT_AC_BIT]        = ac_prev_q;
        rd_byte[sr_timing_pkg::STAT_DRIVE_ONE_BIT] = rectifier_drive_one;
        rd_byte[sr_timing_pkg::STAT_DRIVE_TWO_BIT] = rectifier_drive_two;
      end
      default: rd_byte = 8'h00;
    endcase
  end

  // Ready stands high while no answer is pending, so a master that raises
  // arvalid first and waits for ready is always served.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rdata <= '0;
      s_axi_rresp <= sr_timing_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= mapped(ar_idx) ? sr_timing_pkg::RESP_OKAY
                                    : sr_timing_pkg::RESP_SLVERR;
    end
  end

  // ************************************************************************
  // AC edge detection and half-cycle measurement
  // ************************************************************************
  logic          ac_rise;
  logic          ac_fall;
  logic [CW-1:0] seg_cnt_q;
  logic [CW-1:0] high_len_q;
  logic [CW-1:0] low_len_q;
  logic          resonant;

  assign ac_rise  = ac_edge_sense_input && !ac_prev_q;
  assign ac_fall  = !ac_edge_sense_input && ac_prev_q;
  assign resonant = control_q[sr_timing_pkg::CTRL_RESONANT_BIT];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ac_prev_q <= 1'b0;
    end else begin
      ac_prev_q <= ac_edge_sense_input;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seg_cnt_q <= '0;
    end else begin
      if (ac_rise || ac_fall) begin
        seg_cnt_q <= '0;
      end else if (seg_cnt_q != {CW{1'b1}}) begin
        seg_cnt_q <= seg_cnt_q + CW'(1);
      end
    end
  end

  // The fall must come before an edge that has not happened yet, so the
  // length of the last half-cycle at the same level serves as the prediction of the next one.
  // A frequency step therefore moves the early fall for one cycle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      high_len_q <= '0;
      low_len_q  <= '0;
    end else if (ac_fall) begin
      high_len_q <= seg_cnt_q + CW'(1);
    end else if (ac_rise) begin
      low_len_q <= seg_cnt_q + CW'(1);
    end
  end

  // ************************************************************************
  // Drive channels
  // ************************************************************************
  logic [OW-1:0] rise_one;
  logic [OW-1:0] lead_one;
  logic [OW-1:0] rise_two;
  logic [OW-1:0] lead_two;

  assign rise_one = code_to_cycles(rect1_rise_delay_q);
  assign lead_one = lead_to_cycles(rect1_fall_lead_q);
  assign rise_two = code_to_cycles(rect2_rise_delay_q);
  assign lead_two = lead_to_cycles(rect2_fall_lead_q);

  sr_drive_channel #(.CW(CW), .OW(OW)) u_drive_one (
    .clk         (clk),
    .reset_n     (reset_n),
    .enable      (resonant),
    .start_pulse (ac_rise),
    .stop_pulse  (ac_fall),
    .rise_cycles (rise_one),
    .lead_cycles (lead_one),
    .half_cycles (high_len_q),
    .drive       (rectifier_drive_one)
  );

  sr_drive_channel #(.CW(CW), .OW(OW)) u_drive_two (
    .clk         (clk),
    .reset_n     (reset_n),
    .enable      (resonant),
    .start_pulse (ac_fall),
    .stop_pulse  (ac_rise),
    .rise_cycles (rise_two),
    .lead_cycles (lead_two),
    .half_cycles (low_len_q),
    .drive       (rectifier_drive_two)
  );
endmodule : resonant_sr_dead_time

// ==== rtl/sr_timing_pkg.sv ====
// Constants shared by the rectifier dead-time timing block.
package sr_timing_pkg;
  // **********************************************************************
  // Register indices (byte address is four times the index)
  // **********************************************************************
  localparam logic [7:0] IDX_RECT1_RISE_DELAY = 8'h51;
  localparam logic [7:0] IDX_RECT1_FALL_LEAD  = 8'h53;
  localparam logic [7:0] IDX_RECT2_RISE_DELAY = 8'h55;
  localparam logic [7:0] IDX_RECT2_FALL_LEAD  = 8'h57;
  localparam logic [7:0] IDX_CONTROL          = 8'h59;
  localparam logic [7:0] IDX_STATUS           = 8'h5a;

  // **********************************************************************
  // Field positions and reset values
  // **********************************************************************
  localparam int         CTRL_RESONANT_BIT  = 0;
  localparam int         STAT_AC_BIT        = 0;
  localparam int         STAT_DRIVE_ONE_BIT = 1;
  localparam int         STAT_DRIVE_TWO_BIT = 2;
  localparam logic [7:0] DEAD_TIME_RESET    = 8'h00;
  localparam logic [7:0] CONTROL_RESET      = 8'h00;

  // **********************************************************************
  // Timing
  // **********************************************************************
  localparam int LSB_NS   = 5;
  localparam int CLK_NS   = 40;
  localparam int MAX_CODE = 255;
  // Longest offset, 1275 ns, in whole clock cycles rounded up.
  localparam int MAX_OFFSET_CYCLES = (MAX_CODE * LSB_NS + CLK_NS - 1) / CLK_NS;
  // Clocks from an AC edge to the drive flop: detect, then register.
  localparam int EDGE_LATENCY = 2;

  // **********************************************************************
  // Bus responses
  // **********************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sr_timing_pkg

// ==== rtl/sr_drive_channel.sv ====
// One rectifier drive: delayed rise, predicted early fall.
`timescale 1ns/1ps
module sr_drive_channel #(
  parameter int CW = 16,
  parameter int OW = 6
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          reset_n,
  // Enable and half-cycle markers
  input  wire logic          enable,
  input  wire logic          start_pulse,
  input  wire logic          stop_pulse,
  // Offsets in cycles and predicted half-cycle length
  input  wire logic [OW-1:0] rise_cycles,
  input  wire logic [OW-1:0] lead_cycles,
  input  wire logic [CW-1:0] half_cycles,
  // Drive
  output logic               drive
);
  logic [CW-1:0] cnt_q;
  logic          active_q;
  logic [OW-1:0] rise_q;
  logic [CW-1:0] fall_pt_q;

  // Offsets are latched only at the half-cycle start, so a register write
  // in mid-cycle never splits one pulse between old and new values.
  // latch at start
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rise_q    <= '0;
      fall_pt_q <= '0;
    end else if (start_pulse) begin
      rise_q <= rise_cycles;
      if (half_cycles > CW'(lead_cycles)) begin
        fall_pt_q <= half_cycles - CW'(lead_cycles);
      end else begin
        fall_pt_q <= '0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q    <= '0;
      active_q <= 1'b0;
    end else if (start_pulse) begin
      cnt_q    <= '0;
      active_q <= enable;
    end else if (stop_pulse || !enable) begin
      active_q <= 1'b0;
    end else if (active_q && cnt_q != {CW{1'b1}}) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      drive <= 1'b0;
    end else begin
      drive <= active_q && !stop_pulse && enable &&
               cnt_q >= CW'(rise_q) && cnt_q < fall_pt_q;
    end
  end
endmodule : sr_drive_channel

// ==== tb/ac_edge_source.sv ====
// Sensed AC square wave that stands in for the rectifier's far side.
`timescale 1ns/1ps
module ac_edge_source (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Control
  input  wire logic        run,
  input  wire logic [15:0] half,
  // Sensed AC level
  output logic             ac
);
  logic [15:0] cnt_q;

  // Equal halves keep the predicted fall time steady; parked low when off.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 16'h0;
      ac    <= 1'b0;
    end else if (!run) begin
      cnt_q <= 16'h0;
      ac    <= 1'b0;
    end else if (cnt_q == half - 16'h1) begin
      cnt_q <= 16'h0;
      ac    <= ~ac;
    end else begin
      cnt_q <= cnt_q + 16'h1;
    end
  end
endmodule : ac_edge_source

// ==== tb/resonant_sr_dead_time_props.sv ====
// Concurrent checks on the rectifier dead-time block's ports.
`timescale 1ns/1ps
module sr_dead_time_props (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  // AC sense and drives
  input wire logic        ac_edge_sense_input,
  input wire logic        rectifier_drive_one,
  input wire logic        rectifier_drive_two
);
  wire ac = ac_edge_sense_input;
  wire d1 = rectifier_drive_one;
  wire d2 = rectifier_drive_two;

  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_drives_apart: assert property (!(d1 && d2))
    else $error("both rectifier drives high");
  a_one_off_low: assert property ((!ac)[*3] |-> !d1)
    else $error("drive one high in low half");
  a_two_off_high: assert property (ac[*3] |-> !d2)
    else $error("drive two high in high half");
  a_one_rise_cause: assert property ($rose(d1) |-> ac && $past(ac))
    else $error("drive one rose outside high half");
  a_two_rise_cause: assert property ($rose(d2) |-> !ac && !$past(ac))
    else $error("drive two rose outside low half");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 0)
    else $error("read data wider than a byte");
  c_one_rise: cover property ($rose(d1));
  c_two_rise: cover property ($rose(d2));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : sr_dead_time_props

bind resonant_sr_dead_time sr_dead_time_props i_sr_dead_time_props (
  .clk, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .ac_edge_sense_input,
  .rectifier_drive_one, .rectifier_drive_two);

// ==== tb/resonant_sr_dead_time_tb.sv ====
// Self-checking bench for the resonant rectifier dead-time block.
`timescale 1ns/1ps
module resonant_sr_dead_time_tb;
  logic        clk = 1'b0, reset_n = 1'b0, run = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, rdat;
  logic [1:0]  br, rr, resp;
  logic [3:0]  wsb = 4'hf;
  localparam logic [31:0] STS_ADDR = {22'h0, sr_timing_pkg::IDX_STATUS, 2'b00};
  logic        awr, wr_rdy, bv, arr, rv, ac, d1, d2;
  int          errors = 0, tests_run = 0, mdl[4], ri, s;

  always #20 clk = ~clk;

  resonant_sr_dead_time i_resonant_sr_dead_time (.clk(clk),
    .reset_n(reset_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(wsb),
    .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .ac_edge_sense_input(ac), .rectifier_drive_one(d1),
    .rectifier_drive_two(d2));
  ac_edge_source i_ac_edge_source (.clk(clk), .reset_n(reset_n),
    .run(run), .half(16'd100), .ac(ac));

  // ****************
  // Shared tasks
  // ****************
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask : chk

  // A wait that used up its bound ends the run at once.
  task automatic guard(input int n);
    if (n >= 400) begin
      errors++;
      $display("CHECK FAILED at %0t: wait timed out", $time);
      tally_and_finish();
    end
  endtask : guard

  function automatic logic [31:0] ba(input int i);
    return {22'h0, sr_timing_pkg::IDX_RECT1_RISE_DELAY + 8'(2 * i), 2'b00};
  endfunction : ba

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    bre <= 1'b1;
    for (n = 0; n < 400; n++) begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_rdy) wv <= 1'b0;
      if (bv) break;
    end
    guard(n);
    resp = br;
    bre <= 1'b0;
  endtask : wr

  task automatic rd(input logic [31:0] a, input int e, input logic [1:0] er);
    int n;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    for (n = 0; n < 400; n++) begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv) break;
    end
    guard(n);
    chk(rdat, 32'(e));
    chk(32'(rr), 32'(er));
    rre <= 1'b0;
  endtask : rd

  task automatic wait_lvl(input logic l);
    int n;
    for (n = 0; n < 400; n++) begin
      @(posedge clk);
      #1;
      if (ac === l) break;
    end
    guard(n);
  endtask : wait_lvl

  // Rise counted from the first cycle of the half; lead from the drive's
  // low cycles before the half ends, one cycle of detection allowed.
  task automatic meas(input logic pol, input int rc, input int lc);
    int k, n, g;
    wait_lvl(!pol);
    wait_lvl(pol);
    for (k = 1; k < 400; k++) begin
      @(posedge clk);
      #1;
      if ((pol ? d1 : d2) === 1'b1) break;
    end
    guard(k);
    chk(32'(k), 32'(2 + (rc * 5 + 39) / 40));
    g = 0;
    for (n = 0; n < 400 && ac === pol; n++) begin
      @(posedge clk);
      #1;
      if ((pol ? d1 : d2) !== 1'b1) g++;
    end
    guard(n);
    lc = (lc * 5 + 39) / 40;
    chk(32'(g >= lc && g <= lc + 1), 32'h1);
  endtask : meas

  // ****************
  // Main sequence
  // ****************
  initial begin
    void'($urandom(34));
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    for (ri = 0; ri < 5; ri++) rd(ba(ri), 0, sr_timing_pkg::RESP_OKAY);
    for (ri = 0; ri < 4; ri++) begin
      mdl[ri] = $urandom;
      wr(ba(ri), 32'(mdl[ri]));
      chk(32'(resp), 32'(sr_timing_pkg::RESP_OKAY));
      mdl[ri] &= 255;
    end
    for (ri = 0; ri < 4; ri++) rd(ba(ri), mdl[ri], 2'h0);
    // A write with its low strobe clear must leave the register alone.
    wsb <= 4'h0;
    wr(ba(0), 32'(~mdl[0] & 255));
    chk(32'(resp), 32'(sr_timing_pkg::RESP_OKAY));
    wsb <= 4'hf;
    rd(ba(0), mdl[0], 2'h0);
    wr(32'h148, 32'hff);
    chk(32'(resp), 32'(sr_timing_pkg::RESP_SLVERR));
    rd(32'h148, 0, sr_timing_pkg::RESP_SLVERR);
    wr(ba(4), 32'h1);
    run <= 1'b1;
    // Drives need one measured half before they pulse.
    wait_lvl(1'b1);
    wait_lvl(1'b0);
    // New codes land mid-half; they must wait for the next half start.
    for (s = 0; s < 3; s++) begin
      for (ri = 0; ri < 4; ri++) begin
        mdl[ri] = (s == 0) ? 0 : (s == 1) ? 255 : $urandom_range(255);
        wr(ba(ri), 32'(mdl[ri]));
      end
      // Drive one of this half still runs on the codes of the last round.
      chk(32'(d1), 32'(s == 1));
      if (s > 0) begin
        rd(STS_ADDR, (s == 1) ? 3 : 1, sr_timing_pkg::RESP_OKAY);
      end
      meas(1'b1, mdl[0], mdl[1]);
      meas(1'b0, mdl[2], mdl[3]);
    end
    tally_and_finish();
  end
endmodule : resonant_sr_dead_time_tb
